// ===== core/prio_fields_cfg.svh
`ifndef PRIO_FIELDS_CFG_SVH
`define PRIO_FIELDS_CFG_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define PRIO_NUM_REGS 8
`define PRIO_NUM_SRC 14
`define PRIO_IDX_MISS 4'h8

// ----------------------------------------------------------------------
// Register byte addresses on the APB bus
// ----------------------------------------------------------------------
`define OFF_ADC_TX 8'h0c
`define OFF_CHG_BUS 8'h10
`define OFF_EXT_ONE 8'h14
`define OFF_EXT_TWO 8'h1c
`define OFF_CAPTURE 8'h24
`define OFF_MODULATOR 8'h38
`define OFF_FAULT_CAL 8'h3c
`define OFF_ERR_FLTB 8'h40

// ----------------------------------------------------------------------
// Register slots in the storage array
// ----------------------------------------------------------------------
`define IDX_ADC_TX 0
`define IDX_CHG_BUS 1
`define IDX_EXT_ONE 2
`define IDX_EXT_TWO 3
`define IDX_CAPTURE 4
`define IDX_MODULATOR 5
`define IDX_FAULT_CAL 6
`define IDX_ERR_FLTB 7

// ----------------------------------------------------------------------
// Implemented bit masks per register
// ----------------------------------------------------------------------
`define MASK_ADC_TX 16'h0077
`define MASK_CHG_BUS 16'h7777
`define MASK_EXT_ONE 16'h0007
`define MASK_EXT_TWO 16'h0070
`define MASK_CAPTURE 16'h0070
`define MASK_MODULATOR 16'h0070
`define MASK_FAULT_CAL 16'h7700
`define MASK_ERR_FLTB 16'h0077

// ----------------------------------------------------------------------
// Reset values per register
// ----------------------------------------------------------------------
`define RST_ADC_TX 16'h0044
`define RST_CHG_BUS 16'h4444
`define RST_EXT_ONE 16'h0004
`define RST_EXT_TWO 16'h0040
`define RST_CAPTURE 16'h0040
`define RST_MODULATOR 16'h0040
`define RST_FAULT_CAL 16'h4400
`define RST_ERR_FLTB 16'h0040

// ----------------------------------------------------------------------
// Field low bit positions
// ----------------------------------------------------------------------
`define POS_HIGH 12
`define POS_UPPER 8
`define POS_MID 4
`define POS_LOW 0

// ----------------------------------------------------------------------
// Priority level codes
// ----------------------------------------------------------------------
`define PRIO_DISABLED 3'h0
`define PRIO_LOWEST 3'h1
`define PRIO_RESET_LEVEL 3'h4
`define PRIO_HIGHEST 3'h7

`endif

// ===== core/prio_fields_pkg.sv
package prio_fields_pkg;

   // A priority code and one stored register word.
   typedef logic [2:0] prio_t;
   typedef logic [15:0] word_t;
   typedef logic [3:0] slot_t;

   // Interrupt sources in the order of the source vectors.
   typedef enum {
      SRC_CONV_DONE,
      SRC_SERIAL_TX,
      SRC_PIN_CHANGE,
      SRC_COMPARATOR,
      SRC_TWOWIRE_MASTER,
      SRC_TWOWIRE_SLAVE,
      SRC_EXT_PIN_ONE,
      SRC_EXT_PIN_TWO,
      SRC_CAPTURE_THREE,
      SRC_MODULATOR_EVENT,
      SRC_FAULT_A,
      SRC_CALENDAR,
      SRC_SERIAL_ERROR,
      SRC_FAULT_B
   } src_e;

endpackage : prio_fields_pkg

// ===== core/prio_word_reg.sv
`timescale 1ns/1ps
`include "prio_fields_cfg.svh"

module prio_word_reg
   import prio_fields_pkg::*;
#(
   parameter word_t MASK = 16'hffff,
   parameter word_t RESET_VALUE = 16'h0000
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic wrEn,
   input wire logic [1:0] byteEn,
   input wire word_t wrData,
   output word_t word
);

   word_t word_reg;
   word_t word_next;
   word_t laneMask;

   // ----------------------------------------------------------------------
   // Masked byte-lane update
   // ----------------------------------------------------------------------

   // Only implemented bits are ever stored, so unused bits read back zero.
   always_comb begin
      laneMask = {{8{byteEn[1]}}, {8{byteEn[0]}}} & MASK;
      word_next = word_reg;
      if (wrEn) begin
         word_next = (word_reg & ~laneMask) | (wrData & laneMask);
      end
   end

   // Power-on value loads from the per-field reset marks.
   always_ff @(posedge clock) begin
      if (rst) begin
         word_reg <= RESET_VALUE;
      end else begin
         word_reg <= word_next;
      end
   end

   assign word = word_reg;

   a_unused_bits_zero: assert property (@(posedge clock) disable iff (rst)
      (word_reg & ~MASK) == 16'h0000)
      else $error("Unused bit of a priority word is set.");

endmodule : prio_word_reg

// ===== core/interrupt_priority_fields.sv
// Overview of operation
// - Field value is the priority level
// - Level zero blocks its source entirely
// - Unused bits read zero, ignore writes
// - Reset loads level four, except fault B
// - Converter bits 6-4, transmit bits 2-0
// - Change, comparator, two-wire master and slave
// - External pin one in bits 2-0
// - External pin two in bits 6-4
// - Capture channel three in bits 6-4
// - Modulator event in bits 6-4
// - Fault A 14-12, calendar 10-8
// - Receive error 6-4, fault B 2-0
`timescale 1ns/1ps
`include "prio_fields_cfg.svh"

module interrupt_priority_fields
   import prio_fields_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [13:0] reqIn,
   output logic [13:0] reqQualified,
   output logic [13:0] srcEnabled,
   output prio_t conv_done_priority,
   output prio_t serial_tx_priority,
   output prio_t pin_change_priority,
   output prio_t comparator_priority,
   output prio_t twowire_master_priority,
   output prio_t twowire_slave_priority,
   output prio_t ext_pin_one_priority,
   output prio_t ext_pin_two_priority,
   output prio_t capture_three_priority,
   output prio_t modulator_event_priority,
   output prio_t fault_a_priority,
   output prio_t calendar_priority,
   output prio_t serial_error_priority,
   output prio_t fault_b_priority
);

   // ----------------------------------------------------------------------
   // Register map tables
   // ----------------------------------------------------------------------

   localparam word_t MASKS [`PRIO_NUM_REGS] = '{
      `MASK_ADC_TX, `MASK_CHG_BUS, `MASK_EXT_ONE, `MASK_EXT_TWO,
      `MASK_CAPTURE, `MASK_MODULATOR, `MASK_FAULT_CAL, `MASK_ERR_FLTB};
   localparam word_t RESETS [`PRIO_NUM_REGS] = '{
      `RST_ADC_TX, `RST_CHG_BUS, `RST_EXT_ONE, `RST_EXT_TWO,
      `RST_CAPTURE, `RST_MODULATOR, `RST_FAULT_CAL, `RST_ERR_FLTB};

   // Maps a bus address onto a storage slot, or the miss code.
   function automatic slot_t addrSlot(input logic [7:0] addr);
      slot_t slot;
      case (addr)
         `OFF_ADC_TX: slot = 4'(`IDX_ADC_TX);
         `OFF_CHG_BUS: slot = 4'(`IDX_CHG_BUS);
         `OFF_EXT_ONE: slot = 4'(`IDX_EXT_ONE);
         `OFF_EXT_TWO: slot = 4'(`IDX_EXT_TWO);
         `OFF_CAPTURE: slot = 4'(`IDX_CAPTURE);
         `OFF_MODULATOR: slot = 4'(`IDX_MODULATOR);
         `OFF_FAULT_CAL: slot = 4'(`IDX_FAULT_CAL);
         `OFF_ERR_FLTB: slot = 4'(`IDX_ERR_FLTB);
         default: slot = `PRIO_IDX_MISS;
      endcase
      return slot;
   endfunction : addrSlot

   // ----------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------

   slot_t accessSlot;
   slot_t setupSlot;
   logic accessHit;
   logic wrFire;
   word_t words [`PRIO_NUM_REGS];
   logic [31:0] rdData_reg;
   logic [31:0] rdData_next;

   // The slave never inserts wait states, so every access phase is its last.
   always_comb begin
      accessSlot = addrSlot(paddr);
      setupSlot = addrSlot(paddr);
      accessHit = (accessSlot != `PRIO_IDX_MISS);
      wrFire = psel && penable && pwrite && accessHit;
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && !accessHit;

   // ----------------------------------------------------------------------
   // Storage words
   // ----------------------------------------------------------------------

   // Upper byte lanes of the 32-bit bus have no storage behind them.
   generate
      for (genvar r = 0; r < `PRIO_NUM_REGS; r++) begin : g_word
         prio_word_reg #(
            .MASK(MASKS[r]),
            .RESET_VALUE(RESETS[r])
         ) u_word (
            .clock(clock),
            .rst(rst),
            .wrEn(wrFire && (accessSlot == 4'(r))),
            .byteEn(pstrb[1:0]),
            .wrData(pwdata[15:0]),
            .word(words[r])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Read data path
   // ----------------------------------------------------------------------

   // Read data is captured in the setup phase so that prdata is a flop
   // output by the access phase; an unmapped read returns zero.
   always_comb begin
      rdData_next = rdData_reg;
      if (psel && !penable && !pwrite) begin
         rdData_next = 32'h0000_0000;
         if (setupSlot != `PRIO_IDX_MISS) begin
            rdData_next = {16'h0000, words[setupSlot[2:0]]};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rdData_reg <= 32'h0000_0000;
      end else begin
         rdData_reg <= rdData_next;
      end
   end

   assign prdata = rdData_reg;

   // ----------------------------------------------------------------------
   // Priority fields to arbitration
   // ----------------------------------------------------------------------

   // Fields are wired straight from the stored words so they are always live.
   assign conv_done_priority = words[`IDX_ADC_TX][`POS_MID +: 3];
   assign serial_tx_priority = words[`IDX_ADC_TX][`POS_LOW +: 3];
   assign pin_change_priority = words[`IDX_CHG_BUS][`POS_HIGH +: 3];
   assign comparator_priority = words[`IDX_CHG_BUS][`POS_UPPER +: 3];
   assign twowire_master_priority = words[`IDX_CHG_BUS][`POS_MID +: 3];
   assign twowire_slave_priority = words[`IDX_CHG_BUS][`POS_LOW +: 3];
   assign ext_pin_one_priority = words[`IDX_EXT_ONE][`POS_LOW +: 3];
   assign ext_pin_two_priority = words[`IDX_EXT_TWO][`POS_MID +: 3];
   assign capture_three_priority = words[`IDX_CAPTURE][`POS_MID +: 3];
   assign modulator_event_priority = words[`IDX_MODULATOR][`POS_MID +: 3];
   assign fault_a_priority = words[`IDX_FAULT_CAL][`POS_HIGH +: 3];
   assign calendar_priority = words[`IDX_FAULT_CAL][`POS_UPPER +: 3];
   assign serial_error_priority = words[`IDX_ERR_FLTB][`POS_MID +: 3];
   assign fault_b_priority = words[`IDX_ERR_FLTB][`POS_LOW +: 3];

   prio_t prioAll [`PRIO_NUM_SRC];

   // Collects the fields in source order for the gating loop.
   always_comb begin
      prioAll[SRC_CONV_DONE] = conv_done_priority;
      prioAll[SRC_SERIAL_TX] = serial_tx_priority;
      prioAll[SRC_PIN_CHANGE] = pin_change_priority;
      prioAll[SRC_COMPARATOR] = comparator_priority;
      prioAll[SRC_TWOWIRE_MASTER] = twowire_master_priority;
      prioAll[SRC_TWOWIRE_SLAVE] = twowire_slave_priority;
      prioAll[SRC_EXT_PIN_ONE] = ext_pin_one_priority;
      prioAll[SRC_EXT_PIN_TWO] = ext_pin_two_priority;
      prioAll[SRC_CAPTURE_THREE] = capture_three_priority;
      prioAll[SRC_MODULATOR_EVENT] = modulator_event_priority;
      prioAll[SRC_FAULT_A] = fault_a_priority;
      prioAll[SRC_CALENDAR] = calendar_priority;
      prioAll[SRC_SERIAL_ERROR] = serial_error_priority;
      prioAll[SRC_FAULT_B] = fault_b_priority;
   end

   // A zero level removes the request before arbitration ever sees it,
   // whatever the enable and flag logic upstream says. Kept combinational
   // so a request costs no extra cycle of latency.
   generate
      for (genvar s = 0; s < `PRIO_NUM_SRC; s++) begin : g_gate
         assign srcEnabled[s] = (prioAll[s] != `PRIO_DISABLED);
         assign reqQualified[s] = reqIn[s] && srcEnabled[s];
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------

   logic wrBothLanes;
   assign wrBothLanes = wrFire && (pstrb[1:0] == 2'b11);

   // Arbitration side: a nonzero fault A level passes its request, a zero level never does.
   a_level_reaches_arb: assert property (@(posedge clock) disable iff (rst)
      (fault_a_priority >= `PRIO_LOWEST && reqIn[SRC_FAULT_A])
         |-> reqQualified[SRC_FAULT_A])
      else $error("Enabled source request did not pass to arbitration.");

   a_zero_blocks_req: assert property (@(posedge clock) disable iff (rst)
      (reqQualified & ~srcEnabled) == 14'h0000)
      else $error("A disabled source reached arbitration.");

   // Bus side: unused bits, unmapped slots and idle strobe lanes change nothing.
   a_reserved_read_zero: assert property (@(posedge clock) disable iff (rst)
      (psel && penable && !pwrite) |-> prdata[31:15] == 17'h00000)
      else $error("Read data has an unused upper bit set.");

   a_unmapped_write_ignored: assert property (@(posedge clock) disable iff (rst)
      (psel && penable && pwrite && !accessHit) |=>
         ($stable(conv_done_priority) && $stable(fault_b_priority)))
      else $error("Write to an unmapped address changed a field.");

   a_low_lane_gated: assert property (@(posedge clock) disable iff (rst)
      (wrFire && !pstrb[0]) |=>
         ($stable(serial_tx_priority) && $stable(ext_pin_two_priority)))
      else $error("Low byte field changed without its strobe.");

   a_high_lane_gated: assert property (@(posedge clock) disable iff (rst)
      (wrFire && !pstrb[1]) |=>
         ($stable(pin_change_priority) && $stable(calendar_priority)))
      else $error("High byte field changed without its strobe.");

   // Reset and placement: each write lands in its own bits one cycle later.
   a_reset_levels: assert property (@(posedge clock) disable iff (rst)
      $past(rst) |-> (conv_done_priority == `PRIO_RESET_LEVEL
         && calendar_priority == `PRIO_RESET_LEVEL
         && fault_b_priority == `PRIO_DISABLED))
      else $error("Priority fields wrong after reset.");

   a_adc_tx_write: assert property (@(posedge clock) disable iff (rst)
      (wrBothLanes && paddr == `OFF_ADC_TX) |=>
         (conv_done_priority == $past(pwdata[6:4])
         && serial_tx_priority == $past(pwdata[2:0])))
      else $error("Converter or transmit field not updated by write.");

   a_chg_bus_write: assert property (@(posedge clock) disable iff (rst)
      (wrBothLanes && paddr == `OFF_CHG_BUS) |=>
         (pin_change_priority == $past(pwdata[14:12])
         && comparator_priority == $past(pwdata[10:8])
         && twowire_master_priority == $past(pwdata[6:4])
         && twowire_slave_priority == $past(pwdata[2:0])))
      else $error("Change or two-wire field not updated by write.");

   a_ext_one_write: assert property (@(posedge clock) disable iff (rst)
      (wrBothLanes && paddr == `OFF_EXT_ONE) |=>
         ext_pin_one_priority == $past(pwdata[2:0]))
      else $error("External pin one field not updated by write.");

   a_ext_two_write: assert property (@(posedge clock) disable iff (rst)
      (wrBothLanes && paddr == `OFF_EXT_TWO) |=>
         ext_pin_two_priority == $past(pwdata[6:4]))
      else $error("External pin two field not updated by write.");

   a_capture_write: assert property (@(posedge clock) disable iff (rst)
      (wrBothLanes && paddr == `OFF_CAPTURE) |=>
         capture_three_priority == $past(pwdata[6:4]))
      else $error("Capture field not updated by write.");

   a_modulator_write: assert property (@(posedge clock) disable iff (rst)
      (wrBothLanes && paddr == `OFF_MODULATOR) |=>
         modulator_event_priority == $past(pwdata[6:4]))
      else $error("Modulator field not updated by write.");

   a_fault_cal_write: assert property (@(posedge clock) disable iff (rst)
      (wrBothLanes && paddr == `OFF_FAULT_CAL) |=>
         (fault_a_priority == $past(pwdata[14:12])
         && calendar_priority == $past(pwdata[10:8])))
      else $error("Fault A or calendar field not updated by write.");

   a_err_fltb_write: assert property (@(posedge clock) disable iff (rst)
      (wrBothLanes && paddr == `OFF_ERR_FLTB) |=>
         (serial_error_priority == $past(pwdata[6:4])
         && fault_b_priority == $past(pwdata[2:0])))
      else $error("Receive error or fault B field not updated by write.");

   // Timing toward arbitration: a new level counts from the next cycle only.
   a_write_gates_next: assert property (@(posedge clock) disable iff (rst)
      (wrBothLanes && paddr == `OFF_ERR_FLTB && pwdata[2:0] == 3'h0
         && reqIn[SRC_FAULT_B]) |=> (reqIn[SRC_FAULT_B]
         |-> !reqQualified[SRC_FAULT_B]))
      else $error("Zero level write did not gate the next cycle.");

   a_idle_no_change: assert property (@(posedge clock) disable iff (rst)
      !wrFire |=> $stable(conv_done_priority) && $stable(fault_a_priority))
      else $error("Priority field changed without a write.");

   // Main scenarios; a read may follow a write at once or after an idle cycle.
   c_write_hit: cover property (@(posedge clock) disable iff (rst)
      wrBothLanes ##[1:2] psel && !penable && !pwrite);
   c_unmapped_access: cover property (@(posedge clock) disable iff (rst)
      pslverr);
   c_source_blocked: cover property (@(posedge clock) disable iff (rst)
      reqIn[SRC_CONV_DONE] && !srcEnabled[SRC_CONV_DONE]);
   c_top_level_request: cover property (@(posedge clock) disable iff (rst)
      reqQualified[SRC_FAULT_A] && fault_a_priority == `PRIO_HIGHEST);

endmodule : interrupt_priority_fields

// ===== verif/arb_partner.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Arbitration model on the far side of the priority fields
// ------------------------------------------------------------
module arb_partner
   import prio_fields_pkg::*;
(
   input wire logic [13:0] reqQualified,
   input wire prio_t prios [14],
   output prio_t topLevel
);

   // The highest level among qualified requests wins; a level of zero never can.
   always_comb begin
      topLevel = 3'h0;
      for (int i = 0; i < 14; i++) begin
         if (reqQualified[i] && prios[i] != 3'h0 && prios[i] > topLevel) begin
            topLevel = prios[i];
         end
      end
   end

endmodule : arb_partner

// ===== verif/test_interrupt_priority_fields.sv
`timescale 1ns/1ps
`include "prio_fields_cfg.svh"

module test_interrupt_priority_fields
   import prio_fields_pkg::*;
;
   // ------------------------------------------------------------
   // Signals and expected register images
   // ------------------------------------------------------------
   logic clock, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic [13:0] reqIn, reqQualified, srcEnabled;
   prio_t fld [14];
   prio_t topLevel;
   word_t expReg [8];
   int badCount, samplesChecked, cycles;
   integer seed;
   localparam word_t MASKS [8] = '{`MASK_ADC_TX, `MASK_CHG_BUS, `MASK_EXT_ONE, `MASK_EXT_TWO,
      `MASK_CAPTURE, `MASK_MODULATOR, `MASK_FAULT_CAL, `MASK_ERR_FLTB};
   localparam word_t RSTS [8] = '{`RST_ADC_TX, `RST_CHG_BUS, `RST_EXT_ONE, `RST_EXT_TWO,
      `RST_CAPTURE, `RST_MODULATOR, `RST_FAULT_CAL, `RST_ERR_FLTB};
   localparam logic [7:0] ADDRS [8] = '{`OFF_ADC_TX, `OFF_CHG_BUS, `OFF_EXT_ONE, `OFF_EXT_TWO,
      `OFF_CAPTURE, `OFF_MODULATOR, `OFF_FAULT_CAL, `OFF_ERR_FLTB};
   // Register slot and low bit of each source's field, in source order.
   localparam int SREG [14] = '{0, 0, 1, 1, 1, 1, 2, 3, 4, 5, 6, 6, 7, 7};
   localparam int SPOS [14] = '{4, 0, 12, 8, 4, 0, 0, 4, 4, 4, 12, 8, 4, 0};

   // ------------------------------------------------------------
   // Design and partner
   // ------------------------------------------------------------
   interrupt_priority_fields u_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .reqIn(reqIn), .reqQualified(reqQualified),
      .srcEnabled(srcEnabled), .conv_done_priority(fld[0]), .serial_tx_priority(fld[1]),
      .pin_change_priority(fld[2]), .comparator_priority(fld[3]),
      .twowire_master_priority(fld[4]), .twowire_slave_priority(fld[5]),
      .ext_pin_one_priority(fld[6]), .ext_pin_two_priority(fld[7]),
      .capture_three_priority(fld[8]), .modulator_event_priority(fld[9]),
      .fault_a_priority(fld[10]), .calendar_priority(fld[11]),
      .serial_error_priority(fld[12]), .fault_b_priority(fld[13]));

   arb_partner u_arb (.reqQualified(reqQualified), .prios(fld), .topLevel(topLevel));

   // ------------------------------------------------------------
   // Clock and hang guard
   // ------------------------------------------------------------
   // The run needs under a thousand cycles; the ceiling leaves ample margin.
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         badCount++;
         summarize();
      end
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task summarize;
      $display("checks=%0d mismatches=%0d", samplesChecked, badCount);
      if (badCount == 0 && samplesChecked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize

   task check(input logic [31:0] got, input logic [31:0] want);
      samplesChecked++;
      if (got !== want) begin
         badCount++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask : check

   function automatic prio_t lvl(int i);
      return prio_t'(expReg[SREG[i]] >> SPOS[i]);
   endfunction : lvl

   // One APB transfer; the request is held until pready is seen high at an edge.
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
         output logic [31:0] rd, output logic err);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Writes a slot with junk in the upper half and updates the expected image.
   task wr(input int r, input word_t d, input logic [3:0] s);
      logic [31:0] rd;
      logic err;
      word_t be;
      be = {{8{s[1]}}, {8{s[0]}}};
      apb(1'b1, ADDRS[r], {16'(seed), d}, s, rd, err);
      check(err, 32'h0);
      expReg[r] = (expReg[r] & ~(be & MASKS[r])) | (d & be & MASKS[r]);
   endtask : wr

   task checkRegs;
      logic [31:0] rd;
      logic err;
      for (int r = 0; r < 8; r++) begin
         apb(1'b0, ADDRS[r], 32'h0, 4'h0, rd, err);
         check(rd, {16'h0000, expReg[r]});
         check(err, 32'h0);
      end
   endtask : checkRegs

   // Field ports, enables, qualified requests and the winning level.
   task checkPorts;
      prio_t top;
      prio_t l;
      @(negedge clock);
      top = 3'h0;
      for (int i = 0; i < 14; i++) begin
         l = lvl(i);
         check(fld[i], l);
         check(srcEnabled[i], l != 3'h0);
         check(reqQualified[i], reqIn[i] && l != 3'h0);
         if (reqIn[i] && l > top) begin
            top = l;
         end
      end
      check(topLevel, top);
   endtask : checkPorts

   task doReset;
      @(posedge clock);
      rst <= 1'b1;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      expReg = RSTS;
   endtask : doReset

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] rd;
      logic err;
      int r;
      seed = 32'h3c34;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
      reqIn = 14'h3fff;
      doReset();
      checkRegs();
      checkPorts();
      for (r = 0; r < 8; r++) wr(r, 16'hffff, 4'h3);
      checkPorts();
      checkRegs();
      for (r = 0; r < 8; r++) wr(r, 16'h0000, 4'h3);
      checkPorts();
      apb(1'b1, 8'h00, 32'hffffffff, 4'hf, rd, err);
      check(err, 32'h1);
      apb(1'b0, 8'h44, 32'h0, 4'h0, rd, err);
      check(rd, 32'h0);
      check(err, 32'h1);
      // The refused write above must have left every mapped word untouched.
      checkRegs();
      // Random traffic, including writes with only one byte lane enabled.
      repeat (80) begin
         r = $unsigned($random(seed)) % 8;
         @(posedge clock);
         reqIn <= 14'($random(seed));
         wr(r, 16'($random(seed)), 4'($random(seed)));
         checkPorts();
         apb(1'b0, ADDRS[r], 32'h0, 4'h0, rd, err);
         check(rd, {16'h0000, expReg[r]});
      end
      doReset();
      checkRegs();
      checkPorts();
      summarize();
   end

endmodule : test_interrupt_priority_fields
